// ---- fdp_cfg.svh ----
// Constants for the flash and debug protection controller.
`ifndef FDP_CFG_SVH
`define FDP_CFG_SVH

`define FDP_ROWS 16
`define FDP_ROW_W 4
`define FDP_MASK_RST 16'h0000
`define FDP_MODE_RST 2'h0
`define FDP_DBG_EN_RST 1'h1
`define FDP_SECURE_RST 1'h0

`endif

// ---- fdp_ctrl.sv ----
// Flash protection mode machine, row protection, debug gate and device security lock.
//
// Notes on behaviour
// - Debug enabled out of reset; only firmware may turn it off.
// - Debug re-enable needs full erase, protection cleared, then firmware enable, in order.
// - Maximum security permanently blocks programming, debug and test interfaces.
// - Protection starts open; open imposes no access restriction.
// - Open to protected accepted; protected refuses debug interface accesses.
// - Protected to open only after whole flash erased; earlier requests denied.
// - Open to kill accepted; kill refuses every debug access.
// - In kill, external erase requests are rejected.
// - Kill is terminal across commands, erases and resets.
// - Per-row protection blocks writes and separately blocks reads.
// - Internal system-call flash operations are serviced in every mode once the stored state is loaded.
// - Serial wire debug carries all programming and debug, gated by protection.
`timescale 1ns/1ps
`include "fdp_cfg.svh"
module fdp_ctrl
	import fdp_pkg::*;
(
	// Clock, reset and enable.
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Persisted state presented by nonvolatile storage, caught after reset release.
	input wire logic [1:0] nv_mode,
	input wire logic nv_debug_dis,
	input wire logic nv_secure,
	// Firmware controls.
	input wire logic fw_debug_off,
	input wire logic fw_debug_on,
	input wire logic fw_secure_set,
	input wire logic fw_row_we,
	input wire logic [`FDP_ROW_W-1:0] fw_row_idx,
	input wire logic fw_row_wp,
	input wire logic fw_row_rp,
	// Protection mode change request from firmware or probe.
	input wire logic mode_req,
	input wire logic [1:0] mode_req_target,
	// Whole-flash erase from the probe, and completion from the flash.
	input wire logic ext_erase_req,
	input wire logic erase_done,
	// Serial wire debug access request.
	input wire logic dbg_req,
	input wire logic [1:0] dbg_op,
	input wire logic [`FDP_ROW_W-1:0] dbg_row,
	// Internal system-call access request.
	input wire logic sys_req,
	// Status and answers.
	output fdp_pkg::fdp_mode_t mode_q,
	output logic debug_en_q,
	output logic secure_q,
	output logic swd_port_en_q,
	output logic test_port_en_q,
	output logic [`FDP_ROWS-1:0] row_wp_q,
	output logic [`FDP_ROWS-1:0] row_rp_q,
	output logic mode_rej_q,
	output logic erase_start_q,
	output logic erase_rej_q,
	output logic dbg_grant_q,
	output logic dbg_deny_q,
	output logic sys_grant_q
);
	import fdp_pkg::*;

	function automatic logic row_bit(input logic [`FDP_ROWS-1:0] mask, input logic [`FDP_ROW_W-1:0] row);
		row_bit = mask[row];
	endfunction

	// =====================================================================
	// State
	// =====================================================================
	fdp_mode_t mode_d;
	logic debug_en_d;
	logic secure_d;
	logic swd_port_en_d;
	logic test_port_en_d;
	logic [`FDP_ROWS-1:0] row_wp_d;
	logic [`FDP_ROWS-1:0] row_rp_d;
	logic mode_rej_d;
	logic erase_start_d;
	logic erase_rej_d;
	logic dbg_grant_d;
	logic dbg_deny_d;
	logic sys_grant_d;
	logic loaded_q;
	logic loaded_d;
	logic erase_busy_q;
	logic erase_busy_d;
	// Set by a whole erase finished while protected; allows the return to open.
	logic erased_q;
	logic erased_d;
	// Re-enable sequence progress while debug is off.
	logic reen_erased_q;
	logic reen_erased_d;
	logic reen_ready;
	logic dbg_ok;

	// =====================================================================
	// Next-state logic
	// =====================================================================
	always_comb begin
		mode_d = mode_q;
		debug_en_d = debug_en_q;
		secure_d = secure_q;
		row_wp_d = row_wp_q;
		row_rp_d = row_rp_q;
		loaded_d = 1'h1;
		erase_busy_d = erase_busy_q;
		erased_d = erased_q;
		reen_erased_d = reen_erased_q;
		mode_rej_d = 1'h0;
		erase_start_d = 1'h0;
		erase_rej_d = 1'h0;
		dbg_grant_d = 1'h0;
		dbg_deny_d = 1'h0;
		sys_grant_d = 1'h0;
		reen_ready = 1'h0;
		dbg_ok = 1'h0;
		if (!loaded_q) begin
			// Persisted state is taken on the first enabled edge after reset, so kill survives reset.
			if (nv_mode == FDP_KILL) begin
				mode_d = FDP_KILL;
			end else if (nv_mode == FDP_PROT) begin
				mode_d = FDP_PROT;
			end else begin
				mode_d = FDP_OPEN;
			end
			debug_en_d = !nv_debug_dis;
			secure_d = nv_secure;
		end else begin
			if (fw_secure_set) begin
				secure_d = 1'h1;
			end
			if (fw_row_we) begin
				row_wp_d[fw_row_idx] = fw_row_wp;
				row_rp_d[fw_row_idx] = fw_row_rp;
			end
			// Re-enable path: erase, then open mode with rows cleared, then firmware enable.
			reen_ready = reen_erased_q && (mode_q == FDP_OPEN) && (row_wp_q == `FDP_MASK_RST)
				&& (row_rp_q == `FDP_MASK_RST);
			if (fw_debug_off) begin
				debug_en_d = 1'h0;
				reen_erased_d = 1'h0;
			end else if (fw_debug_on && !debug_en_q && reen_ready) begin
				debug_en_d = 1'h1;
				reen_erased_d = 1'h0;
			end
			// Mode transitions: only the listed ones, anything else is refused.
			if (mode_req) begin
				if (mode_q == FDP_OPEN && mode_req_target == FDP_PROT) begin
					mode_d = FDP_PROT;
					erased_d = 1'h0;
				end else if (mode_q == FDP_OPEN && mode_req_target == FDP_KILL) begin
					mode_d = FDP_KILL;
				end else if (mode_q == FDP_PROT && mode_req_target == FDP_OPEN && erased_q) begin
					mode_d = FDP_OPEN;
					erased_d = 1'h0;
				end else begin
					mode_rej_d = 1'h1;
				end
			end
			// External whole erase: never in kill or under the security lock.
			if (ext_erase_req) begin
				if (mode_q == FDP_KILL || secure_q || erase_busy_q) begin
					erase_rej_d = 1'h1;
				end else begin
					erase_start_d = 1'h1;
					erase_busy_d = 1'h1;
				end
			end
			if (erase_done && erase_busy_q) begin
				erase_busy_d = 1'h0;
				row_wp_d = `FDP_MASK_RST;
				row_rp_d = `FDP_MASK_RST;
				if (mode_q == FDP_PROT) begin
					erased_d = 1'h1;
				end
				// An erase that lands with a repeated switch-off still counts, so the set wins.
				if (!debug_en_q) begin
					reen_erased_d = 1'h1;
				end
			end
			// Probe accesses pass only in open mode with debug on and no lock.
			dbg_ok = debug_en_q && !secure_q && (mode_q == FDP_OPEN) && !erase_busy_q;
			if (dbg_req) begin
				if (!dbg_ok) begin
					dbg_deny_d = 1'h1;
				end else if (dbg_op == FDP_OP_READ && row_bit(row_rp_q, dbg_row)) begin
					dbg_deny_d = 1'h1;
				end else if ((dbg_op == FDP_OP_WRITE || dbg_op == FDP_OP_ERASE) && row_bit(row_wp_q, dbg_row)) begin
					dbg_deny_d = 1'h1;
				end else begin
					dbg_grant_d = 1'h1;
				end
			end
			if (sys_req) begin
				sys_grant_d = 1'h1;
			end
		end
		swd_port_en_d = loaded_d && !secure_d;
		test_port_en_d = loaded_d && !secure_d;
	end

	// =====================================================================
	// Registers
	// =====================================================================
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= FDP_OPEN;
			debug_en_q <= `FDP_DBG_EN_RST;
			secure_q <= `FDP_SECURE_RST;
			swd_port_en_q <= 1'h0;
			test_port_en_q <= 1'h0;
			row_wp_q <= `FDP_MASK_RST;
			row_rp_q <= `FDP_MASK_RST;
			mode_rej_q <= 1'h0;
			erase_start_q <= 1'h0;
			erase_rej_q <= 1'h0;
			dbg_grant_q <= 1'h0;
			dbg_deny_q <= 1'h0;
			sys_grant_q <= 1'h0;
			loaded_q <= 1'h0;
			erase_busy_q <= 1'h0;
			erased_q <= 1'h0;
			reen_erased_q <= 1'h0;
		end else if (clk_en) begin
			mode_q <= mode_d;
			debug_en_q <= debug_en_d;
			secure_q <= secure_d;
			swd_port_en_q <= swd_port_en_d;
			test_port_en_q <= test_port_en_d;
			row_wp_q <= row_wp_d;
			row_rp_q <= row_rp_d;
			mode_rej_q <= mode_rej_d;
			erase_start_q <= erase_start_d;
			erase_rej_q <= erase_rej_d;
			dbg_grant_q <= dbg_grant_d;
			dbg_deny_q <= dbg_deny_d;
			sys_grant_q <= sys_grant_d;
			loaded_q <= loaded_d;
			erase_busy_q <= erase_busy_d;
			erased_q <= erased_d;
			reen_erased_q <= reen_erased_d;
		end
	end
endmodule

// ---- fdp_ctrl_properties.sv ----
// Port checker for the protection controller.
`timescale 1ns/1ps
module fdp_chk (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Enable and requests.
	input wire logic clk_en,
	input wire logic mode_req,
	input wire logic [1:0] mode_req_target,
	input wire logic ext_erase_req,
	input wire logic dbg_req,
	input wire logic sys_req,
	// Answers.
	input wire logic [1:0] mode_q,
	input wire logic secure_q,
	input wire logic swd_port_en_q,
	input wire logic test_port_en_q,
	input wire logic mode_rej_q,
	input wire logic erase_start_q,
	input wire logic erase_rej_q,
	input wire logic dbg_grant_q,
	input wire logic dbg_deny_q,
	input wire logic sys_grant_q
);
	import fdp_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// Requests before the stored state is loaded get no answer, so they are not judged.
	wire logic take = clk_en && (swd_port_en_q || secure_q);
	a_kill_stays: assert property (mode_q == FDP_KILL |=> mode_q == FDP_KILL)
		else $error("kill left");
	a_grant_gate: assert property (dbg_grant_q |-> $past(mode_q) == FDP_OPEN && !$past(secure_q))
		else $error("bad grant");
	a_prot_deny: assert property (take && dbg_req && mode_q == FDP_PROT |=> dbg_deny_q && !dbg_grant_q)
		else $error("prot access");
	a_kill_erase: assert property (take && ext_erase_req && mode_q == FDP_KILL |=> erase_rej_q && !erase_start_q)
		else $error("kill erase");
	a_sys_serve: assert property (take && sys_req |=> sys_grant_q)
		else $error("no syscall");
	a_bad_move: assert property (take && mode_req && mode_q == FDP_PROT && mode_req_target == 2'h2
		|=> mode_rej_q && mode_q == FDP_PROT) else $error("bad move");
	a_lock_ports: assert property (secure_q |-> !swd_port_en_q && !test_port_en_q)
		else $error("port open");
	a_lock_stays: assert property (secure_q |=> secure_q)
		else $error("lock lost");
	// Open to protected is a request in open mode followed by the new mode with no refusal.
	sequence s_prot_req;
		take && mode_req && mode_q == FDP_OPEN && mode_req_target == 2'h1;
	endsequence
	sequence s_now_prot;
		mode_q == FDP_PROT && !mode_rej_q;
	endsequence
	a_open_prot: assert property (s_prot_req |=> s_now_prot)
		else $error("prot refused");
endmodule
bind fdp_ctrl fdp_chk u_chk(.clk_sys, .sys_rst, .clk_en, .mode_req, .mode_req_target, .ext_erase_req, .dbg_req,
	.sys_req, .mode_q, .secure_q, .swd_port_en_q, .test_port_en_q, .mode_rej_q, .erase_start_q, .erase_rej_q,
	.dbg_grant_q, .dbg_deny_q, .sys_grant_q);

// ---- fdp_pkg.sv ----
// Types for the flash and debug protection controller.
package fdp_pkg;
	typedef enum logic [1:0] {
		FDP_OPEN = 2'h0,
		FDP_PROT = 2'h1,
		FDP_KILL = 2'h2
	} fdp_mode_t;

	typedef enum logic [1:0] {
		FDP_OP_READ = 2'h0,
		FDP_OP_WRITE = 2'h1,
		FDP_OP_ERASE = 2'h2,
		FDP_OP_CORE = 2'h3
	} fdp_op_t;
endpackage

// ---- fdp_probe.sv ----
// Serial wire debug probe model.
`timescale 1ns/1ps
module fdp_probe (
	// Clock.
	input wire logic clk_sys,
	// Access lines.
	output logic dbg_req = 1'h0,
	output logic [1:0] dbg_op = 2'h0,
	output logic [3:0] dbg_row = 4'h0
);
	// Released lines carry the inverse, so a stale value never passes for a request.
	task acc(input logic [1:0] op, input logic [3:0] row);
		@(posedge clk_sys);
		#1;
		{dbg_req, dbg_op, dbg_row} = {1'h1, op, row};
		@(posedge clk_sys);
		#1;
		{dbg_req, dbg_op, dbg_row} = {1'h0, ~op, ~row};
	endtask
endmodule

// ---- tb.sv ----
// Self-checking bench for the protection controller.
`timescale 1ns/1ps
module tb;
	import fdp_pkg::*;
	logic clk_sys = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, nv_debug_dis = 1'h0, nv_secure = 1'h0, dbg_req;
	logic fw_debug_off = 1'h0, fw_debug_on = 1'h0, fw_secure_set = 1'h0, fw_row_we = 1'h0, mode_req = 1'h0;
	logic ext_erase_req = 1'h0, erase_done = 1'h0, sys_req = 1'h0, fw_row_wp = 1'h1, fw_row_rp = 1'h0;
	logic debug_en_q, secure_q, swd_port_en_q, test_port_en_q, mode_rej_q;
	logic erase_start_q, erase_rej_q, dbg_grant_q, dbg_deny_q, sys_grant_q;
	logic [1:0] nv_mode = 2'h0, mode_req_target = 2'h1, dbg_op;
	logic [3:0] fw_row_idx = 4'h3, dbg_row;
	logic [15:0] row_wp_q, row_rp_q;
	logic [6:0] tbl [6] = '{7'h01, 7'h21, 7'h41, 7'h61, 7'h26, 7'h0A};
	fdp_mode_t mode_q;
	int n_fail = 0, checked = 0;
	fdp_ctrl dut(.clk_sys, .sys_rst, .clk_en, .nv_mode, .nv_debug_dis, .nv_secure, .fw_debug_off, .fw_debug_on,
		.fw_secure_set, .fw_row_we, .fw_row_idx, .fw_row_wp, .fw_row_rp, .mode_req, .mode_req_target, .ext_erase_req,
		.erase_done, .dbg_req, .dbg_op, .dbg_row, .sys_req, .mode_q, .debug_en_q, .secure_q, .swd_port_en_q,
		.test_port_en_q, .row_wp_q, .row_rp_q, .mode_rej_q, .erase_start_q, .erase_rej_q, .dbg_grant_q, .dbg_deny_q,
		.sys_grant_q);
	fdp_probe probe(.clk_sys, .dbg_req, .dbg_op, .dbg_row);
	initial forever #50 clk_sys = ~clk_sys;
	task step(input logic [7:0] s);
		@(posedge clk_sys);
		#1;
		{fw_debug_off, fw_debug_on, fw_secure_set, fw_row_we, mode_req, ext_erase_req, erase_done, sys_req} = s;
	endtask
	task go(input logic [7:0] s);
		step(s);
		step(8'h00);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		end_sim;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		#1;
		sys_rst = 1'h0;
		step(8'h00);
		chk({mode_q, debug_en_q, secure_q, swd_port_en_q, row_wp_q | row_rp_q}, {FDP_OPEN, 3'h5, 16'h0000});
		$display("reset test done");
		go(8'h10);
		{fw_row_idx, fw_row_wp, fw_row_rp} = 6'h15;
		go(8'h10);
		chk({row_wp_q, row_rp_q}, 32'h00080020);
		foreach (tbl[i]) begin
			probe.acc(tbl[i][6:5], tbl[i][4:1]);
			chk({dbg_grant_q, dbg_deny_q}, {tbl[i][0], !tbl[i][0]});
		end
		$display("open access test done");
		// With the enable low a row write and a syscall must be ignored and the last deny pulse must stand.
		{fw_row_idx, fw_row_wp, fw_row_rp} = 6'h02;
		clk_en = 1'h0;
		go(8'h11);
		clk_en = 1'h1;
		chk({sys_grant_q, dbg_deny_q, row_wp_q}, 18'h10008);
		$display("freeze test done");
		go(8'h09);
		chk({mode_q, sys_grant_q, mode_rej_q}, {FDP_PROT, 2'h2});
		probe.acc(2'h0, 4'h0);
		chk(dbg_deny_q, 1'h1);
		for (int t = 2; t >= 0; t -= 2) begin
			mode_req_target = 2'(t);
			go(8'h08);
			chk({mode_q, mode_rej_q}, {FDP_PROT, 1'h1});
		end
		go(8'h04);
		chk(erase_start_q, 1'h1);
		go(8'h02);
		go(8'h08);
		chk({mode_q, mode_rej_q, row_wp_q | row_rp_q}, {FDP_OPEN, 17'h0});
		$display("protected test done");
		go(8'h80);
		go(8'h40);
		probe.acc(2'h3, 4'h0);
		chk({debug_en_q, dbg_deny_q}, 2'h1);
		go(8'h04);
		go(8'h02);
		go(8'h40);
		chk(debug_en_q, 1'h1);
		$display("debug test done");
		mode_req_target = 2'h2;
		go(8'h08);
		probe.acc(2'h3, 4'h0);
		chk({mode_q, dbg_deny_q}, {FDP_KILL, 1'h1});
		go(8'h04);
		chk({erase_rej_q, erase_start_q}, 2'h2);
		mode_req_target = 2'h0;
		go(8'h28);
		chk({mode_q, mode_rej_q, secure_q, swd_port_en_q, test_port_en_q}, {FDP_KILL, 4'hC});
		{nv_mode, nv_secure, sys_rst} = 4'hB;
		step(8'h00);
		sys_rst = 1'h0;
		step(8'h00);
		chk({mode_q, secure_q, swd_port_en_q}, {FDP_KILL, 2'h2});
		$display("kill test done");
		end_sim;
	end
endmodule
